// File: rtl/seep_consts.svh
`ifndef SEEP_CONSTS_SVH
`define SEEP_CONSTS_SVH

// ****************************************************************
// bus framing
// ****************************************************************
`define SEEP_DEV_ADDR   7'h50
`define SEEP_BYTE_BITS  4'h8
`define SEEP_ADDR_W     7
`define SEEP_DATA_W     8
`define SEEP_DEPTH      128

// ****************************************************************
// timing
// ****************************************************************
`define SEEP_CLK_NS     5
`define SEEP_TWR_US     5000
`define SEEP_TWR_CYC    ((`SEEP_TWR_US * 1000) / `SEEP_CLK_NS)

`endif

// File: rtl/seep_pkg.sv
package seep_pkg;

    typedef enum logic [2:0] {
        SEEP_IDLE,
        SEEP_DEV,
        SEEP_ADDR,
        SEEP_WDATA,
        SEEP_RDATA,
        SEEP_WAIT
    } seep_state_t;

endpackage

// File: rtl/seep_top.sv
`timescale 1ns/100ps
`include "seep_consts.svh"
// Notes on behaviour
// - sample data bits on rising serial clock edges; clock is input only
// - change read data output on falling serial clock edges only
// - data transition while clock high is a start or stop, never data
// - data pin is open drain: drive low or release only
// - data falling while clock high is start; then expect slave address
// - seven bit slave address 1010000 selects this memory
// - bit after address: high means read, low means write
// - acknowledge each good byte by pulling data low for one clock; the code acks only the first data byte of a write, later ones get no ack
// - address byte sent msb first; top bit ignored, low seven used
// - array holds 128 bytes kept without power
// - data rising while clock high is stop; ends the operation
// - after stop enter power down idle until next start
// - location counter advances per byte; plain read uses counter
// - master ack continues read with wrap; no ack then stop ends it
// - write closed by stop starts timed programming, blocking others
// - while programming, slave address is not acknowledged
module seep_top
    import seep_pkg::*;
#(
    parameter int P_TWR_CYCLES = `SEEP_TWR_CYC,
    parameter int P_BUF_DEPTH  = 2
) (
    input  wire logic I_CLOCK,
    input  wire logic I_RST,
    input  wire logic I_SCL,
    input  wire logic I_SDA,
    output logic      O_SDA,
    output logic      O_SDA_OE,
    output logic      O_BUSY,
    output logic      O_POWER_DOWN
);

    localparam int AW = `SEEP_ADDR_W;
    localparam int DW = `SEEP_DATA_W;
    localparam int EW = AW + DW;
    localparam int PW = (P_BUF_DEPTH > 1) ? $clog2(P_BUF_DEPTH) : 1;
    localparam int CW = $clog2(P_BUF_DEPTH + 1);

    // ****************************************************************
    // pin synchronisers and line events
    // ****************************************************************
    logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            scl_s1_r <= I_SCL;
            scl_s2_r <= scl_s1_r;
            scl_d_r  <= scl_s2_r;
            sda_s1_r <= I_SDA;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
        end
    end

    assign scl_rise  = scl_s2_r & ~scl_d_r;
    assign scl_fall  = ~scl_s2_r & scl_d_r;
    // both clock samples high, so a data edge here is framing, not data
    assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign bus_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

    // ****************************************************************
    // array, write buffer and programming engine
    // ****************************************************************
    logic [DW-1:0] mem_r [`SEEP_DEPTH];
    logic [EW-1:0] buf_r [P_BUF_DEPTH];
    logic [PW-1:0] wr_ptr_r, rd_ptr_r;
    logic [CW-1:0] fill_r;
    logic          in_valid, in_ready, out_valid, out_ready;
    logic          prog_act_r, pend_r;
    logic [31:0]   prog_cnt_r;
    logic [EW-1:0] prog_ent_r, pend_ent_r;

    assign in_ready  = (fill_r != CW'(P_BUF_DEPTH));
    assign out_valid = (fill_r != '0);
    assign out_ready = ~prog_act_r;
    assign in_valid  = bus_stop & pend_r;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r   <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr_r <= (wr_ptr_r == PW'(P_BUF_DEPTH - 1)) ?
                            '0 : wr_ptr_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr_r <= (rd_ptr_r == PW'(P_BUF_DEPTH - 1)) ?
                            '0 : rd_ptr_r + 1'b1;
            end
            fill_r <= fill_r + CW'(in_valid && in_ready)
                             - CW'(out_valid && out_ready);
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (in_valid && in_ready) begin
            buf_r[wr_ptr_r] <= pend_ent_r;
        end
    end

    // the cell is only written when the timed cycle ends, as a real cell would
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            prog_act_r <= 1'b0;
            prog_cnt_r <= '0;
            prog_ent_r <= '0;
        end else if (out_valid && out_ready) begin
            prog_act_r <= 1'b1;
            prog_cnt_r <= '0;
            prog_ent_r <= buf_r[rd_ptr_r];
        end else if (prog_act_r) begin
            if (prog_cnt_r == 32'(P_TWR_CYCLES - 1)) begin
                prog_act_r <= 1'b0;
            end
            prog_cnt_r <= prog_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (prog_act_r && prog_cnt_r == 32'(P_TWR_CYCLES - 1)) begin
            mem_r[prog_ent_r[EW-1:DW]] <= prog_ent_r[DW-1:0];
        end
    end

    assign O_BUSY = out_valid | prog_act_r;

    // ****************************************************************
    // bit engine
    // ****************************************************************
    seep_state_t   state_r;
    logic [3:0]    cnt_r;
    logic [DW-1:0] shift_r, tx_r;
    logic [AW-1:0] ptr_r;
    logic          ack_r, oe_r, ack_ok, is_rx;

    assign is_rx = (state_r == SEEP_DEV) || (state_r == SEEP_ADDR)
                || (state_r == SEEP_WDATA);

    always_comb begin
        ack_ok = 1'b0;
        unique case (state_r)
            SEEP_DEV:   ack_ok = (shift_r[7:1] == `SEEP_DEV_ADDR)
                               & ~O_BUSY;
            SEEP_ADDR:  ack_ok = 1'b1;
            // one byte per write; the buffer must have room for the commit
            SEEP_WDATA: ack_ok = ~pend_r & in_ready;
            SEEP_IDLE, SEEP_RDATA, SEEP_WAIT: ack_ok = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            state_r <= SEEP_IDLE;
            cnt_r   <= '0;
            shift_r <= '0;
            tx_r    <= '0;
            ptr_r   <= '0;
            ack_r   <= 1'b0;
            oe_r    <= 1'b0;
            pend_r  <= 1'b0;
            pend_ent_r <= '0;
        end else if (bus_start) begin
            state_r <= SEEP_DEV;
            cnt_r   <= '0;
            oe_r    <= 1'b0;
            pend_r  <= 1'b0;
        end else if (bus_stop) begin
            state_r <= SEEP_IDLE;
            oe_r    <= 1'b0;
            pend_r  <= 1'b0;
        end else if (scl_fall) begin
            // all pin changes happen with the clock low
            if (is_rx) begin
                oe_r  <= (cnt_r == `SEEP_BYTE_BITS) & ack_ok;
                ack_r <= ack_ok;
            end else if (state_r == SEEP_RDATA) begin
                oe_r <= (cnt_r != `SEEP_BYTE_BITS) & ~tx_r[7];
            end else begin
                oe_r <= 1'b0;
            end
        end else if (scl_rise) begin
            if (cnt_r != `SEEP_BYTE_BITS) begin
                cnt_r <= cnt_r + 4'h1;
                if (is_rx) begin
                    shift_r <= {shift_r[6:0], sda_s2_r};
                end else if (state_r == SEEP_RDATA) begin
                    tx_r <= {tx_r[6:0], 1'b0};
                end
            end else begin
                cnt_r <= '0;
                unique case (state_r)
                    SEEP_DEV: begin
                        if (!ack_r) begin
                            state_r <= SEEP_WAIT;
                        end else if (shift_r[0]) begin
                            state_r <= SEEP_RDATA;
                            tx_r    <= mem_r[ptr_r];
                        end else begin
                            state_r <= SEEP_ADDR;
                        end
                    end
                    SEEP_ADDR: begin
                        ptr_r   <= shift_r[AW-1:0];
                        state_r <= SEEP_WDATA;
                    end
                    SEEP_WDATA: begin
                        if (ack_r) begin
                            pend_r     <= 1'b1;
                            pend_ent_r <= {ptr_r, shift_r};
                            ptr_r      <= ptr_r + 1'b1;
                        end else begin
                            state_r <= SEEP_WAIT;
                        end
                    end
                    SEEP_RDATA: begin
                        // counter wraps naturally at the top location
                        ptr_r <= ptr_r + 1'b1;
                        if (!sda_s2_r) begin
                            tx_r <= mem_r[ptr_r + 1'b1];
                        end else begin
                            state_r <= SEEP_WAIT;
                        end
                    end
                    SEEP_IDLE, SEEP_WAIT: ;
                endcase
            end
        end
    end

    assign O_SDA        = 1'b0;
    assign O_SDA_OE     = oe_r;
    assign O_POWER_DOWN = (state_r == SEEP_IDLE);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    a_sda_open_drain: assert property (O_SDA == 1'b0)
        else $error("data pin driven high");
    a_oe_on_fall: assert property ($changed(O_SDA_OE)
        |-> $past(scl_fall | bus_start | bus_stop))
        else $error("data pin changed outside clock low");
    a_start_to_dev: assert property (bus_start
        |=> state_r == SEEP_DEV && cnt_r == 4'h0 && !O_SDA_OE)
        else $error("start not taken");
    a_stop_idle: assert property (bus_stop ##1 !bus_start
        |-> O_POWER_DOWN)
        else $error("stop did not enter power down");
    a_bit_shift: assert property (scl_rise && is_rx && cnt_r < 4'h8
        && !bus_start && !bus_stop
        |=> cnt_r == $past(cnt_r) + 4'h1 && shift_r[0] == $past(sda_s2_r))
        else $error("bit not captured on rising clock");
    a_busy_nack: assert property (scl_fall && state_r == SEEP_DEV
        && cnt_r == 4'h8 && O_BUSY && !bus_start && !bus_stop
        |=> !O_SDA_OE)
        else $error("address acked while programming");
    a_addr_nack: assert property (scl_fall && state_r == SEEP_DEV
        && cnt_r == 4'h8 && shift_r[7:1] != `SEEP_DEV_ADDR
        |=> !O_SDA_OE)
        else $error("foreign address acked");
    a_addr_low7: assert property (scl_rise && state_r == SEEP_ADDR
        && cnt_r == 4'h8 && !bus_start && !bus_stop
        |=> ptr_r == $past(shift_r[6:0]) && state_r == SEEP_WDATA)
        else $error("address byte not loaded");
    a_read_wrap: assert property (scl_rise && state_r == SEEP_RDATA
        && cnt_r == 4'h8 && !bus_start && !bus_stop
        |=> ptr_r == $past(ptr_r) + 7'h01)
        else $error("read counter did not advance");
    a_stop_commit: assert property (bus_stop && pend_r && in_ready
        |=> O_BUSY)
        else $error("write not committed on stop");

    c_read_more: cover property (scl_rise && state_r == SEEP_RDATA
        && cnt_r == 4'h8 && !sda_s2_r);
    c_write_commit: cover property (in_valid && in_ready);
    c_busy_poll: cover property (scl_fall && state_r == SEEP_DEV
        && cnt_r == 4'h8 && O_BUSY);
    c_prog_done: cover property ($fell(prog_act_r));

endmodule // seep_top

// File: tb/seep_master.sv
`timescale 1ns/100ps
// ********************
// serial bus master
// ********************
module seep_master (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    int hcyc = 8;

    initial begin
        o_scl = 1'b1; // clock stands still high outside frames
        o_sda = 1'b1;
    end

    task automatic hp();
        repeat (hcyc) @(negedge i_clk);
    endtask

    // 1 releases the wire; the pull-up then gives the high level
    task automatic bit_io(input logic b, output logic s);
        o_sda = b;
        repeat (hcyc - 1) @(negedge i_clk);
        o_scl = 1'b1;
        hp();
        s = i_sda;
        o_scl = 1'b0;
        // data only moves a clock after the fall, never with it
        @(negedge i_clk);
    endtask

    task automatic start();
        o_sda = 1'b1;
        hp();
        o_scl = 1'b1;
        hp();
        o_sda = 1'b0;
        hp();
        o_scl = 1'b0;
        @(negedge i_clk);
    endtask

    task automatic stop();
        o_sda = 1'b0;
        hp();
        o_scl = 1'b1;
        hp();
        o_sda = 1'b1;
        hp();
    endtask

    // eight bits msb first, then the ninth clock for the acknowledge
    task automatic xfer(input logic [7:0] d, input logic ai,
                        output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ai, ak);
    endtask
endmodule // seep_master

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic       I_CLOCK = 1'b0;
    logic       I_RST   = 1'b1;
    logic       scl;
    logic       m_sda;
    logic       oe;
    logic       o_sda;
    logic       busy;
    logic       pdn;
    wire        sda_w;
    logic [7:0] q;
    logic       ak;
    int         n_tests    = 0;
    int         n_mismatch = 0;
    int         cyc        = 0;

    // wired-and with the pull-up
    assign sda_w = m_sda & ~oe;

    always #2.5 I_CLOCK = ~I_CLOCK;

    seep_top #(.P_TWR_CYCLES(400)) seep_top_i (
        .I_CLOCK      (I_CLOCK),
        .I_RST        (I_RST),
        .I_SCL        (scl),
        .I_SDA        (sda_w),
        .O_SDA        (o_sda),
        .O_SDA_OE     (oe),
        .O_BUSY       (busy),
        .O_POWER_DOWN (pdn)
    );

    seep_master seep_master_i (
        .i_clk (I_CLOCK),
        .i_sda (sda_w),
        .o_scl (scl),
        .o_sda (m_sda)
    );

    task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wbyte(logic [7:0] d, logic eak);
        seep_master_i.xfer(d, 1'b1, q, ak);
        chk("ack", {7'h00, ak}, {7'h00, eak});
    endtask

    task automatic set_addr(logic [7:0] a);
        seep_master_i.start();
        wbyte(8'hA0, 1'b0);
        wbyte(a, 1'b0);
    endtask

    task automatic t_write(logic [7:0] a, logic [7:0] d);
        set_addr(a);
        wbyte(d, 1'b0);
        seep_master_i.stop();
        repeat (4) @(negedge I_CLOCK);
        chk("power_down", {7'h00, pdn}, 8'h01);
        chk("busy", {7'h00, busy}, 8'h01);
        $display("test write done");
    endtask

    // programming still runs: the address byte gets no acknowledge
    task automatic t_poll();
        int n;
        seep_master_i.start();
        wbyte(8'hA0, 1'b1);
        seep_master_i.stop();
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge I_CLOCK);
            n++;
        end
        chk("busy_end", {7'h00, busy}, 8'h00);
        seep_master_i.start();
        wbyte(8'hA0, 1'b0);
        seep_master_i.stop();
        $display("test poll done");
    endtask

    // random read of the top location, master ack wraps to zero
    task automatic t_seq_read();
        set_addr(8'h7F);
        seep_master_i.start();
        wbyte(8'hA1, 1'b0);
        seep_master_i.xfer(8'hFF, 1'b0, q, ak);
        chk("rd_top", q, 8'hA5);
        seep_master_i.xfer(8'hFF, 1'b1, q, ak);
        chk("rd_wrap", q, 8'h5A);
        seep_master_i.stop();
        $display("test sequential read done");
    endtask

    // slow master; written through 85, read back through 05: top bit ignored
    task automatic t_cur_read();
        seep_master_i.hcyc = 20;
        set_addr(8'h05);
        seep_master_i.stop();
        seep_master_i.start();
        wbyte(8'hA1, 1'b0);
        seep_master_i.xfer(8'hFF, 1'b1, q, ak);
        chk("rd_cur", q, 8'h3C);
        seep_master_i.stop();
        seep_master_i.hcyc = 8;
        $display("test current read done");
    endtask

    task automatic t_bad_addr();
        seep_master_i.start();
        wbyte(8'hA2, 1'b1);
        wbyte(8'h00, 1'b1);
        seep_master_i.stop();
        repeat (4) @(negedge I_CLOCK);
        chk("idle", {6'h00, busy, pdn}, 8'h01);
        $display("test bad address done");
    endtask

    task automatic t_reset();
        repeat (10) @(negedge I_CLOCK);
        I_RST = 1'b0;
        repeat (3) @(negedge I_CLOCK);
        chk("reset", {6'h00, busy, pdn}, 8'h01);
        chk("sda_value", {7'h00, o_sda}, 8'h00);
        $display("test reset done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ********************
    // watchdog
    // ********************
    always @(posedge I_CLOCK) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        t_reset();
        t_write(8'h85, 8'h3C);
        t_poll();
        t_write(8'h7F, 8'hA5);
        t_poll();
        t_write(8'h00, 8'h5A);
        t_poll();
        t_seq_read();
        t_cur_read();
        t_bad_addr();
        finish_test();
    end
endmodule // tb_top
